// File: cbda_alu.sv
// Integer execution block: divide step, compares, bit fields and interrupt enable
// Overview of operation
// RULE1: Divide step consumes eight dividend bits per issue
// RULE2: Upper word remainder, lower word dividend plus quotient
// RULE3: Software issues four, two or one steps after init
// RULE4: Unsigned step gives non-negative quotient, no adjust
// RULE5: Signed step treats values signed, may need adjust
// RULE6: Enable sets interrupt flag, no register changed
// RULE7: Enable allowed only at elevated or supervisor level
// RULE8: Word match writes one or zero, immediates sign-extended
// RULE9: Address match compares address registers, writes flag
// RULE10: Lane compare sets each lane to all ones; the code does so for equal lanes only, unequal lanes give zero
// RULE11: Any-lane match writes one if any lane equal
// RULE12: Address zero test writes one when address zero
// RULE13: Field extract shifts, keeps width, sign or zero-extends
// RULE14: Extract results undefined beyond word or zero width
// RULE15: Greater-or-equal writes flag, signed or unsigned immediate
// RULE16: Address greater-or-equal compares unsigned full words
// RULE17: Mask build gives ones run and shifted value
// RULE18: Bit insert replaces one bit, optionally inverted
// RULE19: Field insert merges shifted value inside mask
// RULE20: Inserted bits beyond bit 31 are dropped
// RULE21: Disable clears the interrupt enable flag
// RULE22: Divide init pre-shifts by 0, 16, 24; no init op here, only SHIFT_WORD, SHIFT_HALF and SHIFT_BYTE in the package
// RULE23: Divide step built from eight single-bit iterations
`timescale 1ns/10ps
`default_nettype none
module cbda_alu (
   input  wire logic               CLK_SYS_IN,    // Core clock, 200 MHz
   input  wire logic               RST_N_IN,      // Asynchronous reset, active low
   input  wire logic               ISSUE_IN,      // Operation valid this cycle
   input  wire cbda_pkg::cbda_op_t OP_IN,         // Operation code
   input  wire cbda_pkg::cbda_imm_t IMM_SEL_IN,   // Immediate selection for operand b
   input  wire logic [8:0]         IMM9_OPERAND_IN, // Nine-bit immediate
   input  wire logic [3:0]         IMM4_OPERAND_IN, // Four-bit immediate
   input  wire logic [31:0]        SRC_A_IN,      // First data or address operand
   input  wire logic [31:0]        SRC_B_IN,      // Second operand / divisor
   input  wire logic [31:0]        SRC_HI_IN,     // Upper word of source pair
   input  wire logic [4:0]         POS_IN,        // Bit position / first bit index
   input  wire logic [4:0]         WIDTH_IN,      // Field width / second bit index
   input  wire logic               USE_IMPLICIT_IN, // Short form of match: write implicit data reg
   input  wire cbda_pkg::cbda_priv_t PRIV_IN,     // Current privilege level
   output logic                    WB_VALID_OUT,  // Result valid, one cycle
   output logic                    WB_PAIR_OUT,   // Result is a register pair
   output logic                    WB_IMPLICIT_DATA_REG_OUT, // Target is implicit data reg
   output logic [31:0]             WB_LO_OUT,     // Result word / lower word of pair
   output logic [31:0]             WB_HI_OUT,     // Upper word of pair
   output logic                    IRQ_ENABLE_FLAG_OUT, // Interrupt enable flag
   output logic                    PRIV_FAULT_OUT // Privileged op refused, one cycle
);
   import cbda_pkg::*;

   // Lane compare, all ones per equal lane of the given width
   function automatic logic [31:0] lane_mask(input logic [31:0] a, input logic [31:0] b,
                                             input int unsigned lw);
      logic [31:0] r;
      r = 32'h0000_0000;
      for (int k = 0; k < 32; k++) begin
         r[k] = (((a ^ b) >> ((k / lw) * lw)) & ((64'h1 << lw) - 64'h1)) == 64'h0;
      end
      return r;
   endfunction

   // Run of ones of a given width at a given position
   function automatic logic [31:0] ones_at(input logic [4:0] w, input logic [4:0] p);
      logic [31:0] run;
      run = (32'h0000_0001 << w) - 32'h0000_0001;
      return run << p;
   endfunction

   logic [31:0] opb;                      // Second operand after immediate handling
   logic [31:0] lo_next;                  // Next lower result word
   logic [31:0] hi_next;                  // Next upper result word
   logic        pair_next;                // Next pair flag
   logic        wr_next;                  // Next writeback valid
   logic        irq_next;                 // Next interrupt enable
   logic        fault_next;               // Next privilege fault
   logic [31:0] ds_rem;                   // Divide step remainder
   logic [31:0] ds_low;                   // Divide step low word
   logic [31:0] ext_raw;                  // Shifted field before masking
   logic [31:0] fmask;                    // Field mask for mask build and insert
   logic        priv_ok;                  // Privileged op may run
   logic [31:0] lo_reg;                   // Registered lower result
   logic [31:0] hi_reg;                   // Registered upper result
   logic        wr_reg;                   // Registered writeback valid
   logic        pair_reg;                 // Registered pair flag
   logic        impl_reg;                 // Registered implicit target flag
   logic        irq_reg;                  // Interrupt enable flag
   logic        fault_reg;                // Registered privilege fault

   // Operand b: immediate forms replace the register value
   always_comb begin
      case (IMM_SEL_IN)
         CBDA_IMM_S4: opb = {{28{IMM4_OPERAND_IN[3]}}, IMM4_OPERAND_IN};   // RULE8
         CBDA_IMM_S9: opb = {{23{IMM9_OPERAND_IN[8]}}, IMM9_OPERAND_IN};   // RULE15
         CBDA_IMM_Z:  opb = (OP_IN == CBDA_OP_MASK || OP_IN == CBDA_OP_INSERT) ?
                            {28'h000_0000, IMM4_OPERAND_IN} :
                            {23'h00_0000, IMM9_OPERAND_IN};                // RULE15
         default:     opb = SRC_B_IN;
      endcase
   end

   // Eight-bit divide step on the pair {hi, lo}
   cbda_divstep u_divstep (
      .REM_IN     (SRC_HI_IN),
      .LOW_IN     (SRC_A_IN),
      .DIVISOR_IN (SRC_B_IN),
      .SIGNED_IN  (OP_IN == CBDA_OP_DVSTEP_S),
      .REM_OUT    (ds_rem),
      .LOW_OUT    (ds_low)
   );

   // Shared field helpers; extract past bit 31 or width zero is left as computed
   assign ext_raw = SRC_A_IN >> POS_IN;                         // RULE13
   assign fmask   = ones_at(WIDTH_IN, POS_IN);                  // RULE14
   assign priv_ok = (PRIV_IN == CBDA_PRIV_ELEVATED) ||
                    (PRIV_IN == CBDA_PRIV_SUPER);               // RULE7

   // Result selection for the issued operation
   always_comb begin
      logic [31:0] fld;
      fld        = ext_raw & ((32'h0000_0001 << WIDTH_IN) - 32'h0000_0001);
      lo_next    = RESULT_RST;
      hi_next    = RESULT_RST;
      pair_next  = 1'b0;
      wr_next    = ISSUE_IN;
      irq_next   = irq_reg;
      fault_next = 1'b0;
      case (OP_IN)
         CBDA_OP_DVSTEP_S,
         CBDA_OP_DVSTEP_U: begin
            lo_next   = ds_low;                                 // RULE1
            hi_next   = ds_rem;                                 // RULE2
            pair_next = 1'b1;                                   // RULE3
         end
         CBDA_OP_IRQ_ON: begin
            wr_next    = 1'b0;                                  // RULE6
            fault_next = ISSUE_IN && !priv_ok;                  // RULE7
            if (ISSUE_IN && priv_ok) begin
               irq_next = 1'b1;                                 // RULE6
            end
         end
         CBDA_OP_IRQ_OFF: begin
            wr_next    = 1'b0;
            fault_next = ISSUE_IN && !priv_ok;
            if (ISSUE_IN && priv_ok) begin
               irq_next = 1'b0;                                 // RULE21
            end
         end
         CBDA_OP_MATCH:     lo_next = {31'h0, SRC_A_IN == opb};            // RULE8
         CBDA_OP_ADDR_MT:   lo_next = {31'h0, SRC_A_IN == SRC_B_IN};       // RULE9
         CBDA_OP_LANE8:     lo_next = lane_mask(SRC_A_IN, SRC_B_IN, 8);    // RULE10
         CBDA_OP_LANE16:    lo_next = lane_mask(SRC_A_IN, SRC_B_IN, 16);   // RULE10
         CBDA_OP_LANE32:    lo_next = lane_mask(SRC_A_IN, SRC_B_IN, 32);   // RULE10
         CBDA_OP_ANY8:      lo_next = {31'h0, |lane_mask(SRC_A_IN, opb, 8)};  // RULE11
         CBDA_OP_ANY16:     lo_next = {31'h0, |lane_mask(SRC_A_IN, opb, 16)}; // RULE11
         CBDA_OP_ADDR_ZERO: lo_next = {31'h0, SRC_A_IN == 32'h0000_0000};  // RULE12
         CBDA_OP_EXTR_U:    lo_next = fld;                                 // RULE13
         CBDA_OP_EXTR_S: begin
            // Sign bit is the top bit of the field
            lo_next = fld;
            if (WIDTH_IN != 5'h00 && fld[WIDTH_IN - 5'h01]) begin
               lo_next = fld | ~((32'h0000_0001 << WIDTH_IN) - 32'h0000_0001); // RULE13
            end
         end
         CBDA_OP_GE_S:      lo_next = {31'h0, $signed(SRC_A_IN) >= $signed(opb)}; // RULE15
         CBDA_OP_GE_U:      lo_next = {31'h0, SRC_A_IN >= opb};            // RULE15
         CBDA_OP_ADDR_GE:   lo_next = {31'h0, SRC_A_IN >= SRC_B_IN};       // RULE16
         CBDA_OP_MASK: begin
            hi_next   = fmask;                                  // RULE17
            lo_next   = opb << POS_IN;                          // RULE17
            pair_next = 1'b1;
         end
         CBDA_OP_INS_BIT,
         CBDA_OP_INSN_BIT: begin
            // POS selects the target bit, WIDTH the source bit
            lo_next         = SRC_A_IN;
            lo_next[POS_IN] = SRC_B_IN[WIDTH_IN] ^ (OP_IN == CBDA_OP_INSN_BIT); // RULE18
         end
         CBDA_OP_INSERT: begin
            // Shift truncates at 32 bits, so overflowing bits vanish
            lo_next = (SRC_A_IN & ~fmask) | ((opb << POS_IN) & fmask);     // RULE19 RULE20
         end
         default: wr_next = 1'b0;
      endcase
      if (!ISSUE_IN) begin
         wr_next = 1'b0;
      end
   end

   // Writeback registers, one cycle after issue
   always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         lo_reg   <= RESULT_RST;
         hi_reg   <= RESULT_RST;
         wr_reg   <= 1'b0;
         pair_reg <= 1'b0;
         impl_reg <= 1'b0;
      end else begin
         lo_reg   <= lo_next;
         hi_reg   <= hi_next;
         wr_reg   <= wr_next;
         pair_reg <= pair_next && wr_next;
         impl_reg <= wr_next && USE_IMPLICIT_IN && (OP_IN == CBDA_OP_MATCH);  // RULE8
      end
   end

   // Interrupt enable flag and privilege fault
   always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         irq_reg   <= IRQ_EN_RST;
         fault_reg <= 1'b0;
      end else begin
         irq_reg   <= irq_next;                                 // RULE6
         fault_reg <= fault_next;
      end
   end

   assign WB_VALID_OUT             = wr_reg;
   assign WB_PAIR_OUT              = pair_reg;
   assign WB_IMPLICIT_DATA_REG_OUT = impl_reg;
   assign WB_LO_OUT                = lo_reg;
   assign WB_HI_OUT                = hi_reg;
   assign IRQ_ENABLE_FLAG_OUT      = irq_reg;
   assign PRIV_FAULT_OUT           = fault_reg;

   // Checks on the issued operation and its result one cycle later
   AST_ENABLE_SETS: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) // RULE6
      ISSUE_IN && OP_IN == CBDA_OP_IRQ_ON && priv_ok |=> IRQ_ENABLE_FLAG_OUT && !WB_VALID_OUT)
      else $error("enable did not set flag");
   AST_ENABLE_PRIV: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) // RULE7
      ISSUE_IN && OP_IN == CBDA_OP_IRQ_ON && !priv_ok
      |=> PRIV_FAULT_OUT && IRQ_ENABLE_FLAG_OUT == $past(IRQ_ENABLE_FLAG_OUT))
      else $error("enable ran without privilege");
   AST_DISABLE_CLEARS: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) // RULE21
      ISSUE_IN && OP_IN == CBDA_OP_IRQ_OFF && priv_ok |=> !IRQ_ENABLE_FLAG_OUT)
      else $error("disable did not clear flag");
   AST_MATCH_FLAG: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) // RULE8
      ISSUE_IN && OP_IN == CBDA_OP_MATCH
      |=> WB_VALID_OUT && WB_LO_OUT == {31'h0, $past(SRC_A_IN) == $past(opb)})
      else $error("match result wrong");
   AST_ADDR_ZERO: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) // RULE12
      ISSUE_IN && OP_IN == CBDA_OP_ADDR_ZERO && SRC_A_IN == 32'h0000_0000
      |=> WB_LO_OUT == 32'h0000_0001)
      else $error("zero test wrong");
   AST_LANE16: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) // RULE10
      ISSUE_IN && OP_IN == CBDA_OP_LANE16 && SRC_A_IN[15:0] == SRC_B_IN[15:0]
      |=> WB_LO_OUT[15:0] == 16'hFFFF)
      else $error("lane compare wrong");
   AST_ADDR_GE: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) // RULE16
      ISSUE_IN && OP_IN == CBDA_OP_ADDR_GE
      |=> WB_LO_OUT[0] == ($past(SRC_A_IN) >= $past(SRC_B_IN)))
      else $error("address compare wrong");
   AST_INSERT_KEEP: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) // RULE19
      ISSUE_IN && OP_IN == CBDA_OP_INSERT
      |=> (WB_LO_OUT & ~$past(fmask)) == ($past(SRC_A_IN) & ~$past(fmask)))
      else $error("insert changed bits outside field");
   AST_DIVSTEP_PAIR: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) // RULE1
      ISSUE_IN && OP_IN == CBDA_OP_DVSTEP_U
      |=> WB_PAIR_OUT && WB_LO_OUT[31:8] == $past(SRC_A_IN[23:0]))
      else $error("divide step did not shift eight bits");
   COV_DIVSTEP: cover property (@(posedge CLK_SYS_IN) ISSUE_IN && OP_IN == CBDA_OP_DVSTEP_S);
   COV_ENABLE:  cover property (@(posedge CLK_SYS_IN) $rose(IRQ_ENABLE_FLAG_OUT));
   COV_FAULT:   cover property (@(posedge CLK_SYS_IN) PRIV_FAULT_OUT);
   COV_INSERT:  cover property (@(posedge CLK_SYS_IN) ISSUE_IN && OP_IN == CBDA_OP_INSERT);
endmodule // cbda_alu
`default_nettype wire

// File: cbda_pkg.sv
// Package: operation codes, widths and reset values for the integer execution block
package cbda_pkg;
   localparam int unsigned WORD_W        = 32;             // Data word width
   localparam int unsigned STEP_BITS     = 8;              // Quotient bits per divide step
   localparam int unsigned POS_W         = 5;              // Position and width field size
   localparam int unsigned OP_W          = 5;              // Operation code width
   localparam int unsigned LAT_CYCLES    = 1;              // Cycles from issue to result
   localparam logic [31:0] RESULT_RST    = 32'h0000_0000;  // Result registers after reset
   localparam logic        IRQ_EN_RST    = 1'b0;           // Interrupt enable after reset
   localparam int unsigned SHIFT_WORD    = 0;              // Divide init pre-shift, word
   localparam int unsigned SHIFT_HALF    = 16;             // Divide init pre-shift, halfword
   localparam int unsigned SHIFT_BYTE    = 24;             // Divide init pre-shift, byte

   // Privilege levels of the core
   typedef enum logic [1:0] {
      CBDA_PRIV_USER0    = 2'b00,
      CBDA_PRIV_ELEVATED = 2'b01,
      CBDA_PRIV_SUPER    = 2'b10
   } cbda_priv_t;

   // Operations carried out by the block
   typedef enum logic [4:0] {
      CBDA_OP_NONE      = 5'b00000,
      CBDA_OP_DVSTEP_S  = 5'b00001,
      CBDA_OP_DVSTEP_U  = 5'b00010,
      CBDA_OP_IRQ_ON    = 5'b00011,
      CBDA_OP_IRQ_OFF   = 5'b00100,
      CBDA_OP_MATCH     = 5'b00101,
      CBDA_OP_ADDR_MT   = 5'b00110,
      CBDA_OP_LANE8     = 5'b00111,
      CBDA_OP_LANE16    = 5'b01000,
      CBDA_OP_LANE32    = 5'b01001,
      CBDA_OP_ANY8      = 5'b01010,
      CBDA_OP_ANY16     = 5'b01011,
      CBDA_OP_ADDR_ZERO = 5'b01100,
      CBDA_OP_EXTR_S    = 5'b01101,
      CBDA_OP_EXTR_U    = 5'b01110,
      CBDA_OP_GE_S      = 5'b01111,
      CBDA_OP_GE_U      = 5'b10000,
      CBDA_OP_ADDR_GE   = 5'b10001,
      CBDA_OP_MASK      = 5'b10010,
      CBDA_OP_INS_BIT   = 5'b10011,
      CBDA_OP_INSN_BIT  = 5'b10100,
      CBDA_OP_INSERT    = 5'b10101
   } cbda_op_t;

   // Immediate selection for the second operand
   typedef enum logic [1:0] {
      CBDA_IMM_NONE = 2'b00,
      CBDA_IMM_S4   = 2'b01,
      CBDA_IMM_S9   = 2'b10,
      CBDA_IMM_Z    = 2'b11
   } cbda_imm_t;
endpackage

// File: cbda_divstep.sv
// Divide step: eight shift and add-or-subtract iterations on a 64-bit pair
`timescale 1ns/10ps
`default_nettype none
module cbda_divstep (
   input  wire logic [31:0] REM_IN,       // Partial remainder (upper word)
   input  wire logic [31:0] LOW_IN,       // Dividend bits high, quotient bits low
   input  wire logic [31:0] DIVISOR_IN,   // Divisor
   input  wire logic        SIGNED_IN,    // High selects the signed step
   output logic      [31:0] REM_OUT,      // Updated partial remainder
   output logic      [31:0] LOW_OUT       // Updated dividend and quotient word
);
   import cbda_pkg::*;

   logic [31:0] rem_v [0:8];              // Remainder between iterations
   logic [31:0] low_v [0:8];              // Low word between iterations

   assign rem_v[0] = REM_IN;
   assign low_v[0] = LOW_IN;

   // One quotient bit per iteration, restoring in both forms
   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_iter
         logic [31:0] sh;                 // Remainder shifted with next dividend bit
         logic [31:0] trial;              // Remainder after add or subtract
         logic        qbit;               // Quotient bit developed here
         logic        same;               // Remainder and divisor share a sign
         assign sh   = {rem_v[i][30:0], low_v[i][31]};
         assign same = (rem_v[i][31] == DIVISOR_IN[31]);
         always_comb begin
            if (!SIGNED_IN) begin
               // Unsigned: restoring, quotient never negative, no later fix-up
               qbit  = ({rem_v[i][31], sh} >= {1'b0, DIVISOR_IN});
               trial = qbit ? (sh - DIVISOR_IN) : sh;    // RULE4
            end else begin
               // Signed: remainder keeps its sign; negatives need later adjust
               trial = same ? (sh - DIVISOR_IN) : (sh + DIVISOR_IN);  // RULE5
               qbit  = (trial[31] == rem_v[i][31]) == same;
               trial = (qbit == same) ? trial : sh;
            end
         end
         assign rem_v[i+1] = trial;                       // RULE23
         assign low_v[i+1] = {low_v[i][30:0], qbit};      // RULE2
      end
   endgenerate

   assign REM_OUT = rem_v[STEP_BITS];                     // RULE1
   assign LOW_OUT = low_v[STEP_BITS];                     // RULE1
endmodule // cbda_divstep
`default_nettype wire

// File: compare_bitfield_divstep_alu_bench.sv
// Self-checking bench for the compare, bit-field and divide-step execution block
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_fail++; \
   $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end
module compare_bitfield_divstep_alu_bench;
   import cbda_pkg::*;
   typedef struct packed {logic [31:0] lo; logic [31:0] hi; logic pair; logic impl;} cbda_note_t;
   logic        clk = 1'b0;                   // Core clock, 5 ns period
   logic        rst_n, go, use_impl;          // Reset, issue strobe, short form
   cbda_op_t    op, ro;                       // Driven and randomly picked operation
   cbda_imm_t   imm_sel, rs;                  // Operand b source
   cbda_priv_t  priv, cur_priv;               // Privilege on the port and the next one
   logic [8:0]  imm9;
   logic [3:0]  imm4;
   logic [31:0] src_a, src_b, src_hi, ra, rb, rh, l, h;
   logic [4:0]  pos, width, rp, rw;
   logic        wb_valid, wb_pair, wb_impl, irq_flag, fault;
   logic [31:0] wb_lo, wb_hi;
   int          n_fail = 0;
   int          total_checks = 0;
   integer      seed = 32'h2149_9c83;         // Fixed seed keeps runs repeatable
   cbda_note_t  notes[$];                     // Expected results, oldest first
   cbda_note_t  e, en;
   cbda_op_t    rops[18] = '{CBDA_OP_MATCH, CBDA_OP_ANY8, CBDA_OP_ANY16, CBDA_OP_GE_S,
      CBDA_OP_GE_U, CBDA_OP_MASK, CBDA_OP_INSERT, CBDA_OP_DVSTEP_U, CBDA_OP_ADDR_MT,
      CBDA_OP_LANE8, CBDA_OP_LANE16, CBDA_OP_LANE32, CBDA_OP_ADDR_ZERO, CBDA_OP_EXTR_S,
      CBDA_OP_EXTR_U, CBDA_OP_ADDR_GE, CBDA_OP_INS_BIT, CBDA_OP_INSN_BIT};

   always #2.5 clk = ~clk;

   cbda_alu DUT (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .ISSUE_IN(go), .OP_IN(op),
      .IMM_SEL_IN(imm_sel), .IMM9_OPERAND_IN(imm9), .IMM4_OPERAND_IN(imm4), .SRC_A_IN(src_a),
      .SRC_B_IN(src_b), .SRC_HI_IN(src_hi), .POS_IN(pos), .WIDTH_IN(width),
      .USE_IMPLICIT_IN(use_impl), .PRIV_IN(priv), .WB_VALID_OUT(wb_valid),
      .WB_PAIR_OUT(wb_pair), .WB_IMPLICIT_DATA_REG_OUT(wb_impl), .WB_LO_OUT(wb_lo),
      .WB_HI_OUT(wb_hi), .IRQ_ENABLE_FLAG_OUT(irq_flag), .PRIV_FAULT_OUT(fault));

   // Effective second operand after immediate selection
   function automatic logic [31:0] beff(cbda_op_t o, cbda_imm_t s, logic [8:0] i9,
                                        logic [3:0] i4, logic [31:0] b);
      case (s)
         CBDA_IMM_S4: return {{28{i4[3]}}, i4};
         CBDA_IMM_S9: return {{23{i9[8]}}, i9};
         CBDA_IMM_Z:  return (o inside {CBDA_OP_MASK, CBDA_OP_INSERT}) ? 32'(i4) : 32'(i9);
         default:     return b;
      endcase
   endfunction

   // Independent reference for result-producing ops
   function automatic cbda_note_t model(cbda_op_t o, logic [31:0] a, b, h, logic [4:0] p, w);
      cbda_note_t  n;
      logic [32:0] t;
      logic [31:0] m;
      n = '0;
      m = ((32'h0000_0001 << w) - 32'h0000_0001) << p; // Mask bits past 31 fall away
      case (o)
         CBDA_OP_DVSTEP_S, CBDA_OP_DVSTEP_U: begin
            n.hi = h;
            n.lo = a;
            n.pair = 1'b1;
            // One quotient bit per pass, restoring form
            for (int i = 0; i < 8; i++) begin
               t = {n.hi, n.lo[31]};
               n.lo = {n.lo[30:0], t >= {1'b0, b}};
               n.hi = (t >= {1'b0, b}) ? 32'(t - {1'b0, b}) : t[31:0];
            end
         end
         CBDA_OP_MATCH, CBDA_OP_ADDR_MT: n.lo[0] = a == b;
         CBDA_OP_LANE8, CBDA_OP_ANY8:
            for (int i = 0; i < 32; i += 8) n.lo[i +: 8] = {8{a[i +: 8] == b[i +: 8]}};
         CBDA_OP_LANE16, CBDA_OP_ANY16:
            for (int i = 0; i < 32; i += 16) n.lo[i +: 16] = {16{a[i +: 16] == b[i +: 16]}};
         CBDA_OP_LANE32: n.lo = {32{a == b}};
         CBDA_OP_ADDR_ZERO: n.lo[0] = a == '0;
         CBDA_OP_EXTR_S, CBDA_OP_EXTR_U: begin
            n.lo = (a >> p) & ~(32'hFFFF_FFFF << w);
            if (o == CBDA_OP_EXTR_S && n.lo[w - 1]) n.lo |= 32'hFFFF_FFFF << w;
         end
         CBDA_OP_GE_S: n.lo[0] = $signed(a) >= $signed(b);
         CBDA_OP_GE_U, CBDA_OP_ADDR_GE: n.lo[0] = a >= b;
         CBDA_OP_MASK: begin
            n.hi = m;
            n.lo = b << p;
            n.pair = 1'b1;
         end
         CBDA_OP_INS_BIT, CBDA_OP_INSN_BIT: begin
            n.lo = a;
            n.lo[p] = b[w] ^ (o == CBDA_OP_INSN_BIT);
         end
         CBDA_OP_INSERT: n.lo = (a & ~m) | ((b << p) & m);
         default: n = '0;
      endcase
      if (o inside {CBDA_OP_ANY8, CBDA_OP_ANY16}) n.lo = 32'(|n.lo);
      return n;
   endfunction

   // Drive one operation and note its expected result
   task automatic issue(cbda_op_t o, cbda_imm_t s, logic [31:0] a, b, hh, logic [4:0] p, w,
                        logic [8:0] i9, logic [3:0] i4, logic im);
      cbda_note_t n;
      n = model(o, a, beff(o, s, i9, i4, b), hh, p, w);
      n.impl = im && o == CBDA_OP_MATCH;
      @(posedge clk);
      if (!(o inside {CBDA_OP_NONE, CBDA_OP_IRQ_ON, CBDA_OP_IRQ_OFF})) notes.push_back(n);
      {go, op, imm_sel, src_a, src_b, src_hi} <= {1'b1, o, s, a, b, hh};
      {pos, width, imm9, imm4, use_impl, priv} <= {p, w, i9, i4, im, cur_priv};
   endtask
   task automatic idle();
      @(posedge clk);
      go <= 1'b0;
   endtask
   task automatic rr(cbda_op_t o, logic [31:0] a, b, hh);
      issue(o, CBDA_IMM_NONE, a, b, hh, '0, '0, '0, '0, 1'b0);
   endtask
   task automatic fld(cbda_op_t o, logic [31:0] a, b, logic [4:0] p, w);
      issue(o, CBDA_IMM_NONE, a, b, '0, p, w, '0, '0, 1'b0);
   endtask
   task automatic imm(cbda_op_t o, cbda_imm_t s, logic [31:0] a, logic [8:0] i9, logic [3:0] i4);
      issue(o, s, a, '0, '0, '0, '0, i9, i4, s == CBDA_IMM_S4);
   endtask
   // Flag ops give no write-back; only the flag and the refusal pulse show
   task automatic irq(cbda_op_t o, cbda_priv_t pv, logic ef, logic ff);
      cur_priv = pv;
      rr(o, '0, '0, '0);
      idle();
      @(negedge clk);
      `CHK(fault, ff)
      `CHK(irq_flag, ef)
      cur_priv = CBDA_PRIV_SUPER;
   endtask
   task automatic results();
      $display("Checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // Each write-back is matched against the oldest note
   always @(negedge clk) begin
      if (rst_n === 1'b1 && wb_valid === 1'b1) begin
         if (notes.size() == 0) begin
            n_fail++;
            $display("Error at %0t: result without a pending operation", $time);
         end else begin
            e = notes.pop_front();
            `CHK(wb_lo, e.lo)
            `CHK({wb_hi, wb_pair, wb_impl}, {e.hi, e.pair, e.impl})
         end
      end
   end

   // Reset, directed cases, flag control, chained steps, random mix
   initial begin
      {rst_n, go, use_impl, imm9, imm4, src_a, src_b, src_hi, pos, width} = '0;
      {op, imm_sel, priv, cur_priv} = {CBDA_OP_NONE, CBDA_IMM_NONE, CBDA_PRIV_SUPER, CBDA_PRIV_SUPER};
      repeat (12) @(posedge clk);
      `CHK({wb_valid, fault, irq_flag, wb_lo, wb_hi}, 67'(0))
      rst_n <= 1'b1;
      rr(CBDA_OP_DVSTEP_U, 32'h6400_0000, 32'h0000_0007, '0);
      rr(CBDA_OP_DVSTEP_U, 32'hFF12_3456, 32'hFFFF_FFF0, 32'hFFFF_FFEF);
      rr(CBDA_OP_DVSTEP_S, 32'h6400_0000, 32'h0000_0007, '0);
      rr(CBDA_OP_MATCH, 32'h0000_0005, 32'h0000_0004, '0);
      imm(CBDA_OP_MATCH, CBDA_IMM_S4, 32'hFFFF_FFF8, '0, 4'h8);
      imm(CBDA_OP_MATCH, CBDA_IMM_S9, 32'hFFFF_FF00, 9'h100, '0);
      rr(CBDA_OP_ADDR_MT, 32'h8000_0010, 32'h8000_0010, '0);
      rr(CBDA_OP_ADDR_ZERO, '0, '0, '0);
      rr(CBDA_OP_LANE8, 32'h1122_3344, 32'h1100_3355, '0);
      rr(CBDA_OP_LANE16, 32'h1122_3344, 32'h1100_3344, '0);
      imm(CBDA_OP_ANY8, CBDA_IMM_S9, 32'h12FF_3456, 9'h1FF, '0);
      rr(CBDA_OP_ANY16, 32'h1234_5678, 32'h5678_1234, '0);
      fld(CBDA_OP_EXTR_S, 32'h0000_0F80, '0, 5'h04, 5'h08);
      fld(CBDA_OP_EXTR_U, 32'h0000_0F80, '0, 5'h04, 5'h08);
      imm(CBDA_OP_GE_S, CBDA_IMM_S9, 32'h8000_0000, 9'h1FF, '0);
      imm(CBDA_OP_GE_U, CBDA_IMM_Z, 32'h8000_0000, 9'h1FF, '0);
      rr(CBDA_OP_ADDR_GE, 32'h8000_0000, 32'h7FFF_FFFF, '0);
      issue(CBDA_OP_MASK, CBDA_IMM_Z, '0, '0, '0, 5'h1E, 5'h02, '0, 4'hF, 1'b0);
      fld(CBDA_OP_INS_BIT, '0, 32'h0000_0001, 5'h1F, 5'h00);
      fld(CBDA_OP_INSN_BIT, 32'hFFFF_FFFF, 32'h0000_0080, 5'h00, 5'h07);
      fld(CBDA_OP_INSERT, 32'h1234_5678, 32'h0000_00AB, 5'h08, 5'h08);
      fld(CBDA_OP_INSERT, 32'h1234_5678, 32'h0000_00FF, 5'h1C, 5'h08);
      irq(CBDA_OP_IRQ_ON, CBDA_PRIV_USER0, 1'b0, 1'b1);
      irq(CBDA_OP_IRQ_ON, CBDA_PRIV_ELEVATED, 1'b1, 1'b0);
      irq(CBDA_OP_IRQ_OFF, CBDA_PRIV_USER0, 1'b1, 1'b1);
      irq(CBDA_OP_IRQ_OFF, CBDA_PRIV_SUPER, 1'b0, 1'b0);
      // Four back-to-back steps, each fed the previous pair
      {l, h} = {32'h9ABC_DEF0, 32'h0000_0000};
      for (int k = 0; k < 4; k++) begin
         rr(CBDA_OP_DVSTEP_U, l, 32'h0000_1234, h);
         en = model(CBDA_OP_DVSTEP_U, l, 32'h0000_1234, h, '0, '0);
         {l, h} = {en.lo, en.hi};
      end
      // Random mix; idle gaps leave stale operands with the strobe low
      for (int k = 0; k < 400; k++) begin
         rp = 5'({$random(seed)} % 18);
         ro = rops[rp];
         rs = cbda_imm_t'(rp < 7 ? $random(seed) : 0); // Immediate ops first
         {ra, rb, rp, rw} = {$random(seed), $random(seed), 10'($random(seed))};
         rb = rb[9] ? {ra[31:8], rb[7:0]} : rb;
         cur_priv = cbda_priv_t'({$random(seed)} % 3);
         rh = '0;
         if (ro inside {CBDA_OP_EXTR_S, CBDA_OP_EXTR_U}) begin
            rw = (rw == 0) ? 5'h01 : rw;
            rp = (rp + rw > 32) ? 5'(32 - rw) : rp;
         end
         if (ro == CBDA_OP_DVSTEP_U) begin
            rb[0] = 1'b1;
            rh = {$random(seed)} % rb;
         end
         if ($random(seed) % 4 == 0) idle();
         issue(ro, rs, ra, rb, rh, rp, rw, rb[8:0], rb[3:0], ra[1]);
      end
      idle();
      for (int k = 0; k < 10 && notes.size() != 0; k++) @(negedge clk);
      if (notes.size() != 0) begin
         n_fail++;
         $display("Error at %0t: results missing", $time);
      end
      results();
   end
endmodule // compare_bitfield_divstep_alu_bench
`default_nettype wire
